// ### src/flash_host_pkg.sv
// Purpose: shared constants and carriers for the flash command host
// Assumes: device pins sampled and driven on core_clk
// Notes:   command codes and host register map live here
package flash_host_pkg;

  localparam logic [7:0] cmd_invalid      = 8'h00;
  localparam logic [7:0] cmd_prog_alt     = 8'h10;
  localparam logic [7:0] cmd_erase_setup  = 8'h20;
  localparam logic [7:0] cmd_prog_setup   = 8'h40;
  localparam logic [7:0] cmd_clear_status = 8'h50;
  localparam logic [7:0] cmd_read_status  = 8'h70;
  localparam logic [7:0] cmd_read_ident   = 8'h90;
  localparam logic [7:0] cmd_suspend      = 8'hb0;
  localparam logic [7:0] cmd_confirm      = 8'hd0;
  localparam logic [7:0] cmd_read_array   = 8'hff;
  localparam logic [7:0] cmd_conc_on      = 8'hcb;
  localparam logic [7:0] cmd_conc_off     = 8'hce;

  localparam int addr_w = 20;
  localparam int bank_bit = 19;
  localparam int ready_bit = 7;

  // Host register offsets
  localparam logic [3:0] reg_addr_off   = 4'h0;
  localparam logic [3:0] reg_data_off   = 4'h1;
  localparam logic [3:0] reg_op_off     = 4'h2;
  localparam logic [3:0] reg_status_off = 4'h3;
  localparam logic [3:0] reg_rdata_off  = 4'h4;
  localparam logic [3:0] reg_pins_off   = 4'h5;
  localparam logic [3:0] reg_slot_off   = 4'h6;

  // Operation codes written to the op register
  localparam logic [3:0] op_read_array  = 4'h1;
  localparam logic [3:0] op_read_status = 4'h2;
  localparam logic [3:0] op_clear_stat  = 4'h3;
  localparam logic [3:0] op_read_ident  = 4'h4;
  localparam logic [3:0] op_program     = 4'h5;
  localparam logic [3:0] op_erase       = 4'h6;
  localparam logic [3:0] op_suspend     = 4'h7;
  localparam logic [3:0] op_resume      = 4'h8;
  localparam logic [3:0] op_conc_on     = 4'h9;
  localparam logic [3:0] op_conc_off    = 4'ha;
  localparam logic [3:0] op_read_data   = 4'hb;

  // Bus cycle timing in core clocks
  localparam int strobe_ns = 60;
  localparam int clk_ns = 10;
  localparam logic [3:0] strobe_cycles =
    4'((strobe_ns + clk_ns - 1) / clk_ns);

  localparam logic [7:0] pins_reset_val = 8'h00;

  typedef struct packed {
    logic [addr_w-1:0] addr;
    logic [15:0]       wdata;
    logic              we_n;
    logic              oe_n;
    logic              ce_n;
    logic              dq_oe;
  } flash_bus_t;

  typedef struct packed {
    logic [3:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } sw_req_t;

  // Read-type commands lock out further writes other than FFh until a read ends
  function automatic logic is_read_cmd(input logic [7:0] c);
    return c == cmd_read_array || c == cmd_read_status ||
           c == cmd_clear_status || c == cmd_read_ident;
  endfunction

endpackage

// ### src/flash_cmd_slots.sv
// Purpose: small register memory of per-bank bookkeeping words
// Assumes: one write port, registered read port
// Notes:   holds the first byte of the last command per bank; all go to slot 0 outside concurrent mode
`timescale 1ns/10ps
module flash_cmd_slots
  import flash_host_pkg::*;
(
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic       ce,
  input  wire logic       wr_en,
  input  wire logic [1:0] wr_idx,
  input  wire logic [7:0] wr_data,
  input  wire logic [1:0] rd_idx,
  output logic      [7:0] rd_data
);
  logic [7:0] mem_reg [4];

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_slot
      always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
          mem_reg[gi] <= cmd_read_array;
        end else if (ce && wr_en && wr_idx == 2'(gi)) begin
          mem_reg[gi] <= wr_data;
        end
      end
    end
  endgenerate

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rd_data <= 8'h00;
    end else if (ce) begin
      rd_data <= mem_reg[rd_idx];
    end
  end
endmodule

// ### src/flash_cmd_host.sv
// Purpose: host controller that issues flash commands over device pins
// Assumes: device pins synchronous to core_clk; one op at a time
// Notes:   software drives ops through the plain register port
// What this block does
// - CBh enables, CEh disables concurrent mode
// - Program: setup then data at same address
// - Erase: 20h then D0h inside block
// - After 70h reads return status byte
// - After 90h address bit zero picks code
// - Concurrent: top address bit selects bank
// - Concurrent pair: two commands, one per bank
// - Read status before switching modes
// - Read-type command issued last; block until read
`timescale 1ns/10ps
module flash_cmd_host
  import flash_host_pkg::*;
(
  input  wire logic              core_clk,
  input  wire logic              rst,
  input  wire logic              clk_en,
  input  wire logic [3:0]        sw_addr,
  input  wire logic [31:0]       sw_wdata,
  input  wire logic              sw_wr,
  input  wire logic              sw_rd,
  output logic      [31:0]       sw_rdata,
  output logic      [addr_w-1:0] flash_addr,
  output logic      [15:0]       dq_out,
  output logic                   dq_oe,
  input  wire logic [15:0]       dq_in,
  output logic                   we_n,
  output logic                   oe_n,
  output logic                   ce_n,
  output logic                   reset_powerdown_pin,
  output logic                   high_voltage_unlock_level,
  output logic                   protect_n
);
  typedef enum logic [5:0] {
    st_idle  = 6'b000001,
    st_wr    = 6'b000010,
    st_wgap  = 6'b000100,
    st_rd    = 6'b001000,
    st_done  = 6'b010000,
    st_rst   = 6'b100000
  } state_t;

  state_t      state_reg;
  logic [3:0]  tick_reg;
  logic [addr_w-1:0] addr_reg;
  logic [15:0] data_reg;
  logic [3:0]  op_reg;
  logic [7:0]  seq_reg [2];
  logic [1:0]  nwr_reg;
  logic [1:0]  wr_idx_reg;
  logic        rd_pend_reg;
  logic        conc_reg;
  logic [1:0]  active_reg;
  logic [1:0]  susp_reg;
  logic [1:0]  susp_prog_reg;
  logic        busy_reg;
  logic        refused_reg;
  logic [15:0] rdata_reg;
  logic [2:0]  pins_reg;
  logic [7:0]  slot_rd;
  logic        slot_wr;
  logic [1:0]  slot_idx_reg;

  // Bank chosen by top address bit in concurrent mode, else bank 0
  function automatic logic bank_of(input logic [addr_w-1:0] a,
                                   input logic c);
    return c ? a[bank_bit] : 1'b0;
  endfunction

  wire logic b = bank_of(addr_reg, conc_reg);
  wire logic any_active = |(active_reg | susp_reg);
  wire logic go = clk_en && sw_wr && sw_addr == reg_op_off &&
                  state_reg == st_idle;

  // Acceptance check for a command on its bank
  function automatic logic legal(input logic [3:0] op,
                                 input logic act, input logic sus,
                                 input logic sprog, input logic anyact,
                                 input logic c);
    logic r;
    r = 1'b1;
    if (sus) begin
      r = op == op_read_array || op == op_read_status ||
          op == op_resume || (!sprog && op == op_program);
    end else if (act) begin
      r = op == op_read_status || op == op_suspend;
    end
    if (op == op_conc_on) r = !anyact;
    if (op == op_conc_off) r = c && !anyact;
    if (op == op_resume && !sus) r = 1'b0;
    return r;
  endfunction

  // First and second bus-cycle bytes for an op
  function automatic logic [15:0] cmd_byte(input logic [3:0] op,
                                           input logic [1:0] n,
                                           input logic [15:0] d);
    logic [15:0] r;
    r = {8'h00, cmd_invalid};
    case (op)
      op_read_array:  r = {8'h00, cmd_read_array};
      op_read_status: r = {8'h00, cmd_read_status};
      op_clear_stat:  r = {8'h00, cmd_clear_status};
      op_read_ident:  r = {8'h00, cmd_read_ident};
      op_program:     r = |n ? d : {8'h00, cmd_prog_setup};
      op_erase:       r = {8'h00, n == 2'd0 ? cmd_erase_setup
                                            : cmd_confirm};
      op_suspend:     r = {8'h00, cmd_suspend};
      op_resume:      r = {8'h00, cmd_confirm};
      op_conc_on:     r = {8'h00, cmd_conc_on};
      op_conc_off:    r = {8'h00, cmd_conc_off};
      default:        r = {8'h00, cmd_invalid};
    endcase
    return r;
  endfunction

  wire logic [15:0] first_word = cmd_byte(op_reg, 2'd0, 16'h0);

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      addr_reg <= '0;
      data_reg <= '0;
      pins_reg <= pins_reset_val[2:0];
    end else if (clk_en && sw_wr && state_reg == st_idle) begin
      case (sw_addr)
        reg_addr_off: addr_reg <= sw_wdata[addr_w-1:0];
        reg_data_off: data_reg <= sw_wdata[15:0];
        reg_pins_off: pins_reg <= sw_wdata[2:0];
        default:      pins_reg <= pins_reg;
      endcase
    end
  end

  // Bus-cycle sequencer
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_reg <= st_rst;
      tick_reg <= '0;
      op_reg <= '0;
      nwr_reg <= '0;
      rd_pend_reg <= 1'b0;
      refused_reg <= 1'b0;
      busy_reg <= 1'b1;
      rdata_reg <= '0;
    end else if (clk_en) begin
      case (state_reg)
        st_rst: begin
          tick_reg <= tick_reg + 4'd1;
          if (tick_reg == strobe_cycles) begin
            state_reg <= st_idle;
            busy_reg <= 1'b0;
          end
        end
        st_idle: begin
          tick_reg <= '0;
          nwr_reg <= '0;
          if (go) begin
            op_reg <= sw_wdata[3:0];
            busy_reg <= 1'b1;
            refused_reg <= 1'b0;
            if (sw_wdata[3:0] == op_read_data) begin
              state_reg <= st_rd;
            end else if (!legal(sw_wdata[3:0], active_reg[b], susp_reg[b],
                         susp_prog_reg[b], any_active, conc_reg) ||
                         (rd_pend_reg && sw_wdata[3:0] != op_read_array)) begin
              refused_reg <= 1'b1;
              state_reg <= st_done;
            end else begin
              state_reg <= st_wr;
            end
          end
        end
        st_wr: begin
          tick_reg <= tick_reg + 4'd1;
          if (tick_reg == strobe_cycles) begin
            tick_reg <= '0;
            nwr_reg <= nwr_reg + 2'd1;
            state_reg <= st_wgap;
          end
        end
        st_wgap: begin
          if ((op_reg == op_program || op_reg == op_erase) &&
              nwr_reg == 2'd1) begin
            state_reg <= st_wr;
          end else begin
            rd_pend_reg <= is_read_cmd(first_word[7:0]);
            state_reg <= st_done;
          end
        end
        st_rd: begin
          tick_reg <= tick_reg + 4'd1;
          if (tick_reg == strobe_cycles) begin
            rdata_reg <= dq_in;
            rd_pend_reg <= 1'b0;
            state_reg <= st_done;
          end
        end
        st_done: begin
          busy_reg <= 1'b0;
          state_reg <= st_idle;
        end
        default: state_reg <= st_idle;
      endcase
    end
  end

  // Shadow of bank sequencer state
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      conc_reg <= 1'b0;
      active_reg <= '0;
      susp_reg <= '0;
      susp_prog_reg <= '0;
    end else if (clk_en && state_reg == st_wgap &&
                 !(nwr_reg == 2'd1 &&
                   (op_reg == op_program || op_reg == op_erase))) begin
      case (op_reg)
        op_program, op_erase: begin
          if (conc_reg) active_reg[b] <= 1'b1;
          else active_reg <= 2'b11;
          susp_reg[b] <= 1'b0;
        end
        op_suspend: begin
          susp_reg[b] <= 1'b1;
          susp_prog_reg[b] <= seq_reg[b] != cmd_erase_setup;
        end
        op_resume: susp_reg[b] <= 1'b0;
        op_conc_on: conc_reg <= 1'b1;
        op_conc_off: conc_reg <= 1'b0;
        default: active_reg <= active_reg;
      endcase
    end else if (clk_en && state_reg == st_rd && tick_reg == strobe_cycles &&
                 dq_in[ready_bit]) begin
      // Ready bit clears the shadow busy state
      if (conc_reg) active_reg[b] <= 1'b0;
      else active_reg <= 2'b00;
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      seq_reg[0] <= cmd_read_array;
      seq_reg[1] <= cmd_read_array;
    end else if (clk_en && state_reg == st_wgap) begin
      seq_reg[b] <= first_word[7:0];
    end
  end

  assign slot_wr = state_reg == st_wgap;

  flash_cmd_slots u_slots (
    .core_clk (core_clk),
    .rst      (rst),
    .ce       (clk_en),
    .wr_en    (slot_wr),
    .wr_idx   ({1'b0, b}),
    .wr_data  (first_word[7:0]),
    .rd_idx   (slot_idx_reg),
    .rd_data  (slot_rd)
  );

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      slot_idx_reg <= '0;
    end else if (clk_en && sw_wr && sw_addr == reg_slot_off) begin
      slot_idx_reg <= sw_wdata[1:0];
    end
  end

  // Device pins, all registered; drive command on low lines
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      flash_addr <= '0;
      dq_out <= '0;
      dq_oe <= 1'b0;
      we_n <= 1'b1;
      oe_n <= 1'b1;
      ce_n <= 1'b1;
      reset_powerdown_pin <= 1'b0;
      high_voltage_unlock_level <= 1'b0;
      protect_n <= 1'b0;
    end else if (clk_en) begin
      reset_powerdown_pin <= state_reg != st_rst && pins_reg[0];
      high_voltage_unlock_level <= pins_reg[1];
      protect_n <= pins_reg[2];
      flash_addr <= addr_reg;
      dq_out <= cmd_byte(op_reg, nwr_reg, data_reg);
      dq_oe <= state_reg == st_wr;
      we_n <= !(state_reg == st_wr && tick_reg != strobe_cycles);
      oe_n <= state_reg != st_rd;
      ce_n <= !(state_reg == st_wr || state_reg == st_rd);
    end
  end

  // Software read port, data one cycle after the strobe
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sw_rdata <= '0;
    end else if (clk_en) begin
      sw_rdata <= '0;
      if (sw_rd) begin
        case (sw_addr)
          reg_addr_off:   sw_rdata <= 32'(addr_reg);
          reg_data_off:   sw_rdata <= 32'(data_reg);
          reg_status_off: sw_rdata <= {24'h0, susp_reg, active_reg,
                                       conc_reg, rd_pend_reg,
                                       refused_reg, busy_reg};
          reg_rdata_off:  sw_rdata <= 32'(rdata_reg);
          reg_pins_off:   sw_rdata <= 32'(pins_reg);
          reg_slot_off:   sw_rdata <= 32'(slot_rd);
          default:        sw_rdata <= '0;
        endcase
      end
    end
  end
endmodule

// ### sim/flash_cmd_host_properties.sv
// Purpose: port checks for the flash command host
// Assumes: one clock domain, rst async active high
// Notes:   bound to every host instance below
`timescale 1ns/10ps
module flash_cmd_host_checker
  import flash_host_pkg::*;
(
  input wire logic              core_clk,
  input wire logic              rst,
  input wire logic [3:0]        sw_addr,
  input wire logic [31:0]       sw_wdata,
  input wire logic              sw_wr,
  input wire logic              sw_rd,
  input wire logic [31:0]       sw_rdata,
  input wire logic [addr_w-1:0] flash_addr,
  input wire logic [15:0]       dq_out,
  input wire logic              dq_oe,
  input wire logic              we_n,
  input wire logic              oe_n,
  input wire logic              ce_n,
  input wire logic              reset_powerdown_pin,
  input wire logic              protect_n
);
  logic pins_wr;
  assign pins_wr = sw_wr && sw_addr == reg_pins_off;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);
  property p_write_drive;
    !we_n |-> !ce_n && dq_oe && oe_n;
  endproperty
  a_write_drive: assert property (p_write_drive)
    else $error("write strobe without select or drive");
  property p_read_release;
    !oe_n |-> !ce_n && !dq_oe;
  endproperty
  a_read_release: assert property (p_read_release)
    else $error("read strobe while driving data");
  property p_write_hold;
    !we_n && $past(!we_n) |-> $stable(dq_out) && $stable(flash_addr);
  endproperty
  a_write_hold: assert property (p_write_hold)
    else $error("address or data moved inside a write");
  property p_write_len;
    $fell(we_n) |-> !we_n [*6];
  endproperty
  a_write_len: assert property (p_write_len)
    else $error("write strobe too short");
  property p_read_len;
    $fell(oe_n) |-> !oe_n [*6];
  endproperty
  a_read_len: assert property (p_read_len)
    else $error("read strobe too short");
  property p_rdata_idle;
    !sw_rd |=> sw_rdata == 32'h0;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data outside its cycle");
  property p_reset_pin;
    $rose(reset_powerdown_pin) |-> $past(pins_wr && sw_wdata[0], 2);
  endproperty
  a_reset_pin: assert property (p_reset_pin)
    else $error("reset pin released without a pins write");
  property p_protect;
    // Pins register then pin flop: two edges after the write
    $changed(protect_n) |->
      $past(pins_wr, 2) && protect_n == $past(sw_wdata[2], 2);
  endproperty
  a_protect: assert property (p_protect)
    else $error("protect pin changed without a pins write");
endmodule
bind flash_cmd_host flash_cmd_host_checker u_chk(.core_clk, .rst, .sw_addr,
  .sw_wdata, .sw_wr, .sw_rd, .sw_rdata, .flash_addr, .dq_out, .dq_oe, .we_n,
  .oe_n, .ce_n, .reset_powerdown_pin, .protect_n);

// ### sim/flash_dev_model.sv
// Purpose: behavioural two-bank flash device facing the host
// Assumes: pins seen on core_clk; sequencer time counted in clocks
// Notes:   identity codes are arbitrary values
`timescale 1ns/10ps
module flash_dev_model
  import flash_host_pkg::*;
#(
  parameter logic [15:0] maker_code  = 16'h00a5,
  parameter logic [15:0] part_code   = 16'h005a,
  parameter int          busy_cycles = 300
)(
  input  wire logic              core_clk,
  input  wire logic [addr_w-1:0] flash_addr,
  input  wire logic [15:0]       dq_out,
  input  wire logic              we_n,
  input  wire logic              oe_n,
  input  wire logic              ce_n,
  input  wire logic              reset_powerdown_pin,
  input  wire logic              high_voltage_unlock_level,
  input  wire logic              protect_n,
  input  wire logic              vpp_low,
  output logic      [15:0]       dq_in
);
  logic [7:0]  st [2];
  logic [1:0]  md [2];
  logic [1:0]  pend [2];
  logic [1:0]  act, sus, m;
  logic        conc, we_q, ce_q, b, rb, lock, busy;
  logic [7:0]  c;
  logic [15:0] last, rv, last_d;
  int          cnt [2];
  int          prog_count = 0;
  int          erase_count = 0;

  assign b = flash_addr[bank_bit];
  assign rb = conc & b;
  assign c = dq_out[7:0];
  assign m = conc ? {b, ~b} : 2'b11;
  assign busy = |(act & ~sus & m);
  // Boot sector is the top 8K words
  assign lock = vpp_low | (&flash_addr[19:13] & ~protect_n
                & ~high_voltage_unlock_level);
  always @(posedge core_clk) begin
    we_q <= we_n;
    ce_q <= ce_n;
    last <= dq_in;
    if (!reset_powerdown_pin) begin
      conc <= 1'b0;
      act <= 2'b00;
      sus <= 2'b00;
      st <= '{8'h80, 8'h80};
      md <= '{2'd0, 2'd0};
      pend <= '{2'd0, 2'd0};
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (act[i] && !sus[i]) begin
          cnt[i] <= cnt[i] - 1;
          if (cnt[i] == 1) begin
            act[i] <= 1'b0;
            for (int j = 0; j < 2; j++) if (!conc || i == j) st[j] <= 8'h80;
          end
        end
      end
      if (we_n && !we_q && !ce_q) begin
        if (pend[b] != 2'd0) begin
          pend[b] <= 2'd0;
          if (!lock && (pend[b] == 2'd1 ||
                        c == cmd_confirm)) begin
            act[b] <= 1'b1;
            cnt[b] <= busy_cycles;
            last_d <= dq_out;
            if (pend[b] == 2'd1) prog_count <= prog_count + 1;
            else erase_count <= erase_count + 1;
            for (int j = 0; j < 2; j++) if (m[j]) st[j] <= 8'h00;
          end
        end else if (!busy || c inside {cmd_read_status, cmd_suspend,
                     cmd_confirm, cmd_conc_on, cmd_conc_off}) begin
          case (c)
            cmd_conc_on, cmd_conc_off: begin
              // Suspended banks still count as active
              if (act == 2'b00 &&
                  (c == cmd_conc_on || conc)) begin
                conc <= (c == cmd_conc_on);
                st <= '{8'h80, 8'h80};
                md <= '{2'd0, 2'd0};
              end
            end
            cmd_read_array: foreach (md[j]) if (m[j]) md[j] <= 2'd0;
            cmd_read_status: foreach (md[j]) if (m[j]) md[j] <= 2'd1;
            cmd_read_ident: foreach (md[j]) if (m[j]) md[j] <= 2'd2;
            cmd_clear_status: foreach (st[j]) if (m[j]) st[j] <= 8'h80;
            cmd_prog_setup, cmd_prog_alt: if (!act[b]) pend[b] <= 2'd1;
            cmd_erase_setup: if (!act[b]) pend[b] <= 2'd2;
            cmd_suspend: sus <= sus | (act & m);
            cmd_confirm: sus <= sus & ~m;
            default: ;
          endcase
        end
      end
    end
  end
  always @* begin
    case (md[rb])
      2'd1: rv = {8'h00, st[rb]};
      2'd2: rv = flash_addr[0] ? part_code : maker_code;
      default: rv = flash_addr[15:0] ^ 16'h3c3c;
    endcase
  end
  // A released bus shows the inverse of its last value
  assign dq_in = (!oe_n && !ce_n && reset_powerdown_pin)
                 ? rv : ~last;
endmodule

// ### sim/test_flash_cmd_host.sv
// Purpose: directed test of the flash command host against a device model
// Assumes: 100 MHz core_clk, rst high for 8 cycles
// Notes:   status bits: 1 refused, 3 concurrent, 5:4 active, 6 bank0 held
`timescale 1ns/10ps
module test_flash_cmd_host;
  import flash_host_pkg::*;
  logic              core_clk, rst, clk_en, sw_wr, sw_rd, vpp_low;
  logic [3:0]        sw_addr;
  logic [31:0]       sw_wdata, sw_rdata, s, d;
  logic [addr_w-1:0] flash_addr;
  logic [15:0]       dq_out, dq_in;
  logic              dq_oe, we_n, oe_n, ce_n, protect_n;
  logic              reset_powerdown_pin, high_voltage_unlock_level;
  int                fails, checked, np, ne;

  flash_cmd_host u_dut(.core_clk, .rst, .clk_en, .sw_addr, .sw_wdata, .sw_wr,
    .sw_rd, .sw_rdata, .flash_addr, .dq_out, .dq_oe, .dq_in, .we_n, .oe_n,
    .ce_n, .reset_powerdown_pin, .high_voltage_unlock_level, .protect_n);
  flash_dev_model u_dev(.core_clk, .flash_addr, .dq_out, .we_n, .oe_n, .ce_n,
    .reset_powerdown_pin, .high_voltage_unlock_level, .protect_n, .vpp_low,
    .dq_in);

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] v);
    sw_addr <= a;
    sw_wdata <= v;
    sw_wr <= 1'b1;
    @(posedge core_clk);
    sw_wr <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic rd(input logic [3:0] a, output logic [31:0] v);
    sw_addr <= a;
    sw_rd <= 1'b1;
    @(posedge core_clk);
    sw_rd <= 1'b0;
    #1 v = sw_rdata;
    @(posedge core_clk);
  endtask
  task automatic op(input logic [3:0] code, input logic [19:0] a,
                    input logic [15:0] v, output logic [31:0] st);
    wr(reg_addr_off, 32'(a));
    wr(reg_data_off, 32'(v));
    wr(reg_op_off, 32'(code));
    st = 32'h1;
    for (int i = 0; i < 100 && st[0] !== 1'b0; i++) rd(reg_status_off, st);
    chk(st[0], 1'b0);
  endtask
  task automatic fetch(input logic [19:0] a, output logic [31:0] v);
    logic [31:0] st;
    op(op_read_data, a, 16'h0, st);
    rd(reg_rdata_off, v);
  endtask
  task automatic wait_ready(input logic [19:0] a);
    logic [31:0] v;
    v = 32'h0;
    for (int i = 0; i < 60 && v[ready_bit] !== 1'b1; i++) begin
      op(op_read_status, a, 16'h0, v);
      fetch(a, v);
    end
    chk(v[ready_bit], 1'b1);
  endtask
  task automatic report_and_stop();
    $display("checked=%0d fails=%0d", checked, fails);
    if (fails == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  initial begin
    #400000;
    fails++;
    report_and_stop();
  end
  initial begin
    {rst, clk_en, sw_wr, sw_rd, vpp_low} = 5'b11000;
    sw_addr = 4'h0;
    sw_wdata = 32'h0;
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    repeat (10) @(posedge core_clk);
    rd(reg_pins_off, d);
    chk(d, 32'(pins_reset_val));
    chk(reset_powerdown_pin, 1'b0);
    rd(4'hf, d);
    chk(d, 32'h0);
    wr(reg_pins_off, 32'h3);
    @(posedge core_clk);
    chk(high_voltage_unlock_level, 1'b1);
    chk(protect_n, 1'b0);
    wr(reg_pins_off, 32'h5);
    @(posedge core_clk);
    chk(reset_powerdown_pin, 1'b1);
    chk(protect_n, 1'b1);
    $display("test pins done");
    op(op_read_status, 20'h0, 16'h0, s);
    fetch(20'h0, d);
    chk(d[15:0], 16'h0080);
    op(op_read_ident, 20'h0, 16'h0, s);
    fetch(20'h0, d);
    chk(d[15:0], u_dev.maker_code);
    fetch(20'h1, d);
    chk(d[15:0], u_dev.part_code);
    $display("test reads done");
    np = u_dev.prog_count;
    ne = u_dev.erase_count;
    op(op_program, 20'h12345, 16'habcd, s);
    chk(u_dev.prog_count, np + 1);
    chk(u_dev.last_d, 16'habcd);
    op(op_erase, 20'h10000, 16'h0, s);
    chk(s[1], 1'b1);
    op(op_conc_on, 20'h0, 16'h0, s);
    chk(s[1], 1'b1);
    chk(u_dev.conc, 1'b0);
    wait_ready(20'h0);
    rd(reg_status_off, s);
    chk(s[5:4], 2'b00);
    $display("test program done");
    op(op_conc_on, 20'h0, 16'h0, s);
    chk(s[3], 1'b1);
    op(op_erase, 20'h00000, 16'h0, s);
    op(op_program, 20'h80010, 16'h5a5a, s);
    chk(u_dev.act, 2'b11);
    chk(u_dev.erase_count, ne + 1);
    op(op_conc_off, 20'h0, 16'h0, s);
    chk(s[1], 1'b1);
    op(op_suspend, 20'h00000, 16'h0, s);
    chk(u_dev.sus, 2'b01);
    op(op_conc_off, 20'h0, 16'h0, s);
    chk(s[1], 1'b1);
    chk(s[6], 1'b1);
    op(op_resume, 20'h00000, 16'h0, s);
    chk(u_dev.sus, 2'b00);
    wait_ready(20'h00000);
    wait_ready(20'h80000);
    wr(reg_slot_off, 32'h1);
    rd(reg_slot_off, d);
    chk(d, 32'(cmd_read_status));
    op(op_conc_off, 20'h0, 16'h0, s);
    chk(s[3], 1'b0);
    chk(u_dev.conc, 1'b0);
    $display("test concurrent done");
    op(op_read_status, 20'h0, 16'h0, s);
    op(op_program, 20'h00020, 16'h1111, s);
    chk(s[1], 1'b1);
    fetch(20'h0, d);
    chk(d[15:0], 16'h0080);
    op(op_clear_stat, 20'h0, 16'h0, s);
    fetch(20'h0, d);
    op(op_read_array, 20'h00123, 16'h0, s);
    fetch(20'h00123, d);
    chk(d[15:0], 16'h0123 ^ 16'h3c3c);
    vpp_low <= 1'b1;
    op(op_program, 20'h00040, 16'h2222, s);
    wait_ready(20'h0);
    chk(u_dev.prog_count, np + 2);
    vpp_low <= 1'b0;
    wr(reg_pins_off, 32'h1);
    op(op_program, 20'hfe000, 16'h3333, s);
    wait_ready(20'h0);
    chk(u_dev.prog_count, np + 2);
    wr(reg_pins_off, 32'h3);
    op(op_program, 20'hfe000, 16'h4444, s);
    wait_ready(20'h0);
    chk(u_dev.prog_count, np + 3);
    $display("test lockout done");
    report_and_stop();
  end
endmodule
